// ---- logic/pdcs_delay_mem.sv ----
// sample delay line for the notch filter, registered read-before-write
// assumes contents are ignored by the user until every word has been written once
module pdcs_delay_mem (
    input  wire logic   CLOCK,
    pdcs_mem_if.mem     port_m
);
    logic [pdcs_pkg::SAMPLE_W-1:0] store [pdcs_pkg::NOTCH_TAPS];
    logic [pdcs_pkg::SAMPLE_W-1:0] rdata_r;

    assign port_m.rdata = rdata_r;

    always_ff @(posedge CLOCK) begin
        rdata_r <= store[port_m.addr];
        if (port_m.wr_en) begin
            store[port_m.addr] <= port_m.wdata;
        end
    end
endmodule : pdcs_delay_mem

// ---- logic/pdcs_mem_if.sv ----
// port bundle between the sequencer and its notch delay memory
// assumes one clock domain; read data returned one cycle after the address
interface pdcs_mem_if;
    logic                                wr_en;
    logic [pdcs_pkg::NOTCH_AW-1:0]       addr;
    logic [pdcs_pkg::SAMPLE_W-1:0]       wdata;
    logic [pdcs_pkg::SAMPLE_W-1:0]       rdata;
    modport user (output wr_en, output addr, output wdata, input rdata);
    modport mem  (input wr_en, input addr, input wdata, output rdata);
endinterface : pdcs_mem_if

// ---- logic/pdcs_pkg.sv ----
// constants, state type and timing counts of the pfc control sequencer
// assumes a single 200 MHz clock and analogue thresholds arriving as comparator flags
package pdcs_pkg;
    localparam int CLK_HZ         = 200000000;
    localparam int CLK_MHZ        = 200;
    // minimum off interval, least time, rounded up
    localparam int TOFF_NS        = 600;
    localparam int TOFF_CYC       = (TOFF_NS * CLK_MHZ + 999) / 1000;
    // sync pulse loss timeout, longest time, rounded down
    localparam int SYNC_TMO_US    = 108;
    localparam int SYNC_TMO_CYC   = SYNC_TMO_US * CLK_MHZ;
    // converter sample rate
    localparam int ADC_RATE_HZ    = 3550;
    localparam int ADC_WIN_CYC    = CLK_HZ / ADC_RATE_HZ;
    localparam int SYNC_LOCK_CNT  = 6;
    // comb notch length: samples per half line period at 50 Hz line
    localparam int NOTCH_TAPS     = 35;
    localparam int NOTCH_AW       = 6;
    localparam int SAMPLE_W       = 17;
    localparam int SUM_W          = 24;
    localparam int WORD_W         = 9;
    localparam logic [8:0] WORD_MAX = 9'h100;
    localparam logic [8:0] SS_INIT  = 9'h000;
    localparam int KP_SHIFT       = 8;
    localparam int KI_SHIFT       = 12;
    localparam int PER_W          = 16;
    localparam int TMR_W          = 24;
    localparam int TOFF_W         = 8;

    typedef enum logic [1:0] {
        PDCS_LOCKOUT,
        PDCS_STANDBY,
        PDCS_SOFTSTART,
        PDCS_NORMAL
    } pdcs_state_t;
endpackage : pdcs_pkg

// ---- logic/pdcs_sequencer.sv ----
// pfc control sequencer: supply lockout, standby, soft-start, sync oscillator,
// digital voltage loop and ramp-crossing pwm turn-on
// assumes all analogue levels arrive as comparator flags synchronous to CLOCK
module pdcs_sequencer #(
    parameter int SYNC_TMO_CYC = pdcs_pkg::SYNC_TMO_CYC,
    parameter int ADC_WIN_CYC  = pdcs_pkg::ADC_WIN_CYC
) (
    input  wire logic                          CLOCK,
    input  wire logic                          RST_B,
    input  wire logic                          SUPPLY_ABOVE_START,
    input  wire logic                          SUPPLY_BELOW_STOP,
    input  wire logic                          BULK_ABOVE_MIN,
    input  wire logic                          LINE_ABOVE_ON,
    input  wire logic                          ENABLE_ABOVE_MIN,
    input  wire logic                          BULK_ABOVE_95,
    input  wire logic                          BULK_BELOW_THRESH,
    input  wire logic                          SYNC_MODE,
    input  wire logic                          SYNC_PULSE,
    input  wire logic [pdcs_pkg::PER_W-1:0]    INT_PERIOD,
    input  wire logic                          SD_BIT,
    input  wire logic                          RAMP_CROSS,
    output logic                               GATE,
    output logic                               RAMP_RELEASE,
    output logic                               BULK_GOOD,
    output logic                               COMP_FORCE,
    output logic [pdcs_pkg::WORD_W-1:0]        LOOP_WORD,
    output logic                               SS_ACTIVE,
    output logic                               SYNC_LOCKED
);
    localparam logic [pdcs_pkg::SUM_W-1:0] TARGET =
        pdcs_pkg::SUM_W'((ADC_WIN_CYC / 2) * pdcs_pkg::NOTCH_TAPS);
    localparam logic [pdcs_pkg::TMR_W-1:0] TMO_LIM = pdcs_pkg::TMR_W'(SYNC_TMO_CYC);
    localparam logic [pdcs_pkg::SAMPLE_W-1:0] WIN_LIM =
        pdcs_pkg::SAMPLE_W'(ADC_WIN_CYC - 1);
    localparam logic [pdcs_pkg::TOFF_W-1:0] TOFF_LIM = pdcs_pkg::TOFF_W'(pdcs_pkg::TOFF_CYC);

    pdcs_pkg::pdcs_state_t state_r, state_nxt;

    // ---------------- operating state ----------------
    wire start_ok   = SUPPLY_ABOVE_START && BULK_ABOVE_MIN && LINE_ABOVE_ON
                      && ENABLE_ABOVE_MIN;
    wire standby_rq = !BULK_ABOVE_MIN || !ENABLE_ABOVE_MIN;
    wire switching  = (state_r == pdcs_pkg::PDCS_SOFTSTART) || (state_r == pdcs_pkg::PDCS_NORMAL);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            pdcs_pkg::PDCS_LOCKOUT:   if (start_ok) state_nxt = pdcs_pkg::PDCS_SOFTSTART;
            pdcs_pkg::PDCS_STANDBY:   if (start_ok) state_nxt = pdcs_pkg::PDCS_SOFTSTART;
            pdcs_pkg::PDCS_SOFTSTART: begin
                if (standby_rq) state_nxt = pdcs_pkg::PDCS_STANDBY;
                else if (BULK_ABOVE_95) state_nxt = pdcs_pkg::PDCS_NORMAL;
            end
            pdcs_pkg::PDCS_NORMAL:    if (standby_rq) state_nxt = pdcs_pkg::PDCS_STANDBY;
            default:                  state_nxt = pdcs_pkg::PDCS_LOCKOUT;
        endcase
        if (SUPPLY_BELOW_STOP) state_nxt = pdcs_pkg::PDCS_LOCKOUT;
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_B) state_r <= pdcs_pkg::PDCS_LOCKOUT;
        else        state_r <= state_nxt;
    end

    // ---------------- bulk good and comp node ----------------
    logic bulk_good_r, comp_force_r;
    wire  bg_clr = BULK_BELOW_THRESH || !(state_nxt == pdcs_pkg::PDCS_SOFTSTART
                   || state_nxt == pdcs_pkg::PDCS_NORMAL);
    wire  bg_set = state_nxt == pdcs_pkg::PDCS_NORMAL && state_r == pdcs_pkg::PDCS_SOFTSTART;

    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            bulk_good_r  <= 1'b0;
            comp_force_r <= 1'b0;
        end else begin
            bulk_good_r  <= !bg_clr && (bg_set || bulk_good_r);
            comp_force_r <= state_nxt == pdcs_pkg::PDCS_STANDBY;
        end
    end
    assign BULK_GOOD  = bulk_good_r;
    assign COMP_FORCE = comp_force_r;
    assign SS_ACTIVE  = state_r == pdcs_pkg::PDCS_SOFTSTART;

    // ---------------- external sync ----------------
    logic                      sync_q_r, locked_r;
    logic [2:0]                pulse_cnt_r;
    logic [pdcs_pkg::TMR_W-1:0] tmr_r;
    wire sync_rise = SYNC_PULSE && !sync_q_r;
    wire sync_lost = tmr_r >= TMO_LIM;
    wire lock_now  = sync_rise && (pulse_cnt_r == 3'(pdcs_pkg::SYNC_LOCK_CNT - 1));

    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            sync_q_r    <= 1'b0;
            locked_r    <= 1'b0;
            pulse_cnt_r <= 3'h0;
            tmr_r       <= '0;
        end else begin
            sync_q_r <= SYNC_PULSE;
            tmr_r    <= sync_rise ? '0 : (sync_lost ? tmr_r : tmr_r + 1'b1);
            if (!SYNC_MODE || (sync_lost && !sync_rise)) begin
                locked_r    <= 1'b0;
                pulse_cnt_r <= 3'h0;
            end else if (sync_rise && !locked_r) begin
                pulse_cnt_r <= pulse_cnt_r + 3'h1;
                locked_r    <= lock_now;
            end
        end
    end
    assign SYNC_LOCKED = locked_r;

    // ---------------- pwm cycle ----------------
    logic [pdcs_pkg::PER_W-1:0]  per_r;
    logic [pdcs_pkg::TOFF_W-1:0] toff_r;
    logic                        gate_r;
    // INT_PERIOD assumed within range set by resistor
    wire int_end     = per_r >= INT_PERIOD - 16'h0001;
    wire cycle_start = locked_r ? sync_rise : int_end;
    wire toff_busy   = toff_r != '0;

    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            per_r  <= '0;
            toff_r <= TOFF_LIM;
            gate_r <= 1'b0;
        end else begin
            per_r <= cycle_start ? '0 : per_r + 16'h0001;
            if (!switching || cycle_start) begin
                toff_r <= TOFF_LIM;
                gate_r <= 1'b0;
            end else begin
                if (toff_busy) toff_r <= toff_r - 8'h01;
                if (!toff_busy && RAMP_CROSS) gate_r <= 1'b1;
            end
        end
    end
    assign GATE         = gate_r;
    assign RAMP_RELEASE = switching && !toff_busy;

    // ---------------- sigma-delta decimator ----------------
    logic [pdcs_pkg::SAMPLE_W-1:0] win_r, ones_r, sample_r;
    logic                          smp_r, filt_r;
    wire win_end = win_r >= WIN_LIM;

    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            win_r    <= '0;
            ones_r   <= '0;
            sample_r <= '0;
            smp_r    <= 1'b0;
        end else begin
            win_r    <= win_end ? '0 : win_r + 17'h00001;
            ones_r   <= win_end ? '0 : ones_r + 17'(SD_BIT);
            smp_r    <= win_end;
            if (win_end) sample_r <= ones_r + 17'(SD_BIT);
        end
    end

    // ---------------- notch: moving sum over a half line period ----------------
    pdcs_mem_if mem_bus ();
    pdcs_delay_mem u_delay (
        .CLOCK  (CLOCK),
        .port_m (mem_bus.mem)
    );
    logic [pdcs_pkg::NOTCH_AW-1:0] ptr_r;
    logic                          full_r;
    logic [pdcs_pkg::SUM_W-1:0]    sum_r;
    wire  ptr_wrap = ptr_r == pdcs_pkg::NOTCH_AW'(pdcs_pkg::NOTCH_TAPS - 1);
    wire [pdcs_pkg::SAMPLE_W-1:0] oldest = full_r ? mem_bus.rdata : '0;

    assign mem_bus.wr_en = smp_r;
    assign mem_bus.addr  = ptr_r;
    assign mem_bus.wdata = sample_r;

    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            ptr_r  <= '0;
            full_r <= 1'b0;
            sum_r  <= '0;
            filt_r <= 1'b0;
        end else begin
            filt_r <= smp_r;
            if (smp_r) ptr_r <= ptr_wrap ? '0 : ptr_r + 6'h01;
            if (filt_r && ptr_r == '0) full_r <= 1'b1;
            if (filt_r) sum_r <= sum_r + 24'(sample_r) - 24'(oldest);
        end
    end

    // ---------------- pi compensator and soft-start ----------------
    logic signed [pdcs_pkg::SUM_W:0] integ_r;
    logic [pdcs_pkg::WORD_W-1:0]     ss_word_r, word_r;
    wire signed [pdcs_pkg::SUM_W:0] err  = $signed({1'b0, TARGET}) - $signed({1'b0, sum_r});
    wire signed [pdcs_pkg::SUM_W:0] i_nx = integ_r + (err >>> pdcs_pkg::KI_SHIFT);
    wire signed [pdcs_pkg::SUM_W:0] i_cl = i_nx < 0 ? '0 :
        (i_nx > $signed(25'(pdcs_pkg::WORD_MAX)) ? 25'(pdcs_pkg::WORD_MAX) : i_nx);
    wire signed [pdcs_pkg::SUM_W:0] pi   = i_cl + (err >>> pdcs_pkg::KP_SHIFT);
    wire [pdcs_pkg::WORD_W-1:0] pi_word = pi < 0 ? '0 :
        (pi > $signed(25'(pdcs_pkg::WORD_MAX)) ? pdcs_pkg::WORD_MAX : pi[8:0]);

    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            integ_r   <= '0;
            ss_word_r <= pdcs_pkg::SS_INIT;
            word_r    <= '0;
        end else if (!switching) begin
            integ_r   <= '0;
            ss_word_r <= pdcs_pkg::SS_INIT;
            word_r    <= '0;
        end else if (state_r == pdcs_pkg::PDCS_SOFTSTART) begin
            integ_r <= 25'(ss_word_r);
            if (filt_r && ss_word_r < pdcs_pkg::WORD_MAX) begin
                ss_word_r <= ss_word_r + 9'h001;
            end
            word_r <= ss_word_r;
        end else if (filt_r) begin
            integ_r <= i_cl;
            word_r  <= pi_word;
        end
    end
    assign LOOP_WORD = word_r;

    // ---------------- checks ----------------
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_B);

    gate_idle_a: assert property (!switching |=> !GATE)
        else $error("gate active while switching disabled");
    start_cond_a: assert property ($past(state_r) == pdcs_pkg::PDCS_LOCKOUT
        && state_r == pdcs_pkg::PDCS_SOFTSTART |-> $past(start_ok))
        else $error("start without supply, bulk and line conditions");
    lockout_a: assert property (SUPPLY_BELOW_STOP |=> state_r == pdcs_pkg::PDCS_LOCKOUT
        ##1 !GATE)
        else $error("no lockout on low supply");
    standby_a: assert property (switching && standby_rq && !SUPPLY_BELOW_STOP
        |=> state_r == pdcs_pkg::PDCS_STANDBY && COMP_FORCE)
        else $error("no standby on low bulk or enable");
    comp_force_a: assert property (COMP_FORCE |-> state_r == pdcs_pkg::PDCS_STANDBY)
        else $error("comp node forced outside standby");
    toff_a: assert property (cycle_start && switching && !SUPPLY_BELOW_STOP
        && !standby_rq |=> (!GATE && !RAMP_RELEASE) [*8])
        else $error("gate or ramp active inside minimum off interval");
    release_a: assert property ($rose(RAMP_RELEASE) && $past(switching)
        |-> $past(toff_r) == 8'h01)
        else $error("ramp released before off interval expired");
    bulk_good_a: assert property (state_r == pdcs_pkg::PDCS_SOFTSTART && BULK_ABOVE_95
        && !standby_rq && !SUPPLY_BELOW_STOP && !BULK_BELOW_THRESH
        |=> BULK_GOOD && !SS_ACTIVE)
        else $error("bulk good not raised at 95 percent");
    bulk_low_a: assert property (BULK_BELOW_THRESH |=> !BULK_GOOD)
        else $error("bulk good held with bulk below threshold");
    word_max_a: assert property (LOOP_WORD <= pdcs_pkg::WORD_MAX)
        else $error("loop word above maximum");
    sample_max_a: assert property (sample_r <= pdcs_pkg::SAMPLE_W'(ADC_WIN_CYC))
        else $error("converter sample above window length");
    notch_sum_a: assert property (sum_r <= 2 * TARGET)
        else $error("moving sum above full scale");
    sync_lock_a: assert property (SYNC_MODE && lock_now && !locked_r
        && !sync_lost |=> SYNC_LOCKED)
        else $error("no lock after sixth pulse");
    sync_early_a: assert property ($rose(SYNC_LOCKED) |-> $past(pulse_cnt_r)
        == 3'(pdcs_pkg::SYNC_LOCK_CNT - 1))
        else $error("lock before sixth pulse");
    sync_fall_a: assert property (SYNC_LOCKED && sync_rise |=> !GATE)
        else $error("gate not ended by sync edge");
    ss_rise_a: assert property (SS_ACTIVE && filt_r && ss_word_r < pdcs_pkg::WORD_MAX
        && !standby_rq && !BULK_ABOVE_95 && !SUPPLY_BELOW_STOP
        |=> ss_word_r == $past(ss_word_r) + 9'h001)
        else $error("soft-start word not stepping");

    lock_c:    cover property ($rose(SYNC_LOCKED));
    unlock_c:  cover property ($fell(SYNC_LOCKED) && SYNC_MODE);
    normal_c:  cover property ($rose(BULK_GOOD));
    standby_c: cover property ($rose(COMP_FORCE));
endmodule : pdcs_sequencer

// ---- tb/pdcs_stage_model.sv ----
// power stage model: ramp comparator, sync pulse source, sigma-delta bit stream
// assumes the bench drives its controls at the falling clock edge
module pdcs_stage_model (
    input  wire logic        clock,
    input  wire logic        ramp_release,
    input  wire logic        sync_on,
    input  wire logic [15:0] sync_per,
    input  wire logic [7:0]  cross_dly,
    input  wire logic [7:0]  sd_fill,
    output logic             ramp_cross,
    output logic             sync_pulse,
    output logic             sd_bit
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] ramp_r = 16'h0000;
    logic [15:0] sync_r = 16'h0000;
    logic [8:0]  sd_r   = 9'h000;
    // ramp discharged while held, crossing stays high once reached
    always @(negedge clock) begin
        ramp_r     <= ramp_release ? ramp_r + 16'h0001 : 16'h0000;
        ramp_cross <= ramp_release && ramp_r >= {8'h00, cross_dly};
        sync_r     <= (sync_on && sync_r < sync_per - 16'h0001) ? sync_r + 16'h0001 : 16'h0000;
        // pulse line stands low outside the pulse train
        sync_pulse <= sync_on && sync_r >= 16'h0001 && sync_r <= 16'h000a;
        // first-order modulator, ones density sd_fill/256
        sd_r       <= {1'b0, sd_r[7:0]} + {1'b0, sd_fill};
        sd_bit     <= sd_r[8];
    end
endmodule : pdcs_stage_model

// ---- tb/testbench.sv ----
// self-checking bench of the pfc control sequencer with a power stage model
// assumes shortened sync timeout and converter window parameters
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TMO = 200;
    localparam int WIN = 64;
    logic        clock = 1'b0;
    logic        rst_b, sup_start, sup_stop, bulk_min, line_on, en_min, bulk_95, bulk_thr;
    logic        sync_mode, sync_on, sd_bit, ramp_cross, sync_pulse, ramp_rel;
    logic        gate, bulk_good, comp_force, ss_active, sync_locked, rel_q, syn_q, gate_q;
    logic        mon_on, armed;
    logic [15:0] int_per, sync_per;
    logic [7:0]  cross_dly, sd_fill;
    logic [8:0]  loop_word, v;
    int          failures, checks, seed, cyc, fall_cyc, gap, low_cnt, rise_cyc, rises, gate_ups;

    pdcs_sequencer #(.SYNC_TMO_CYC(TMO), .ADC_WIN_CYC(WIN)) dut_u (
        .CLOCK(clock), .RST_B(rst_b), .SUPPLY_ABOVE_START(sup_start),
        .SUPPLY_BELOW_STOP(sup_stop), .BULK_ABOVE_MIN(bulk_min), .LINE_ABOVE_ON(line_on),
        .ENABLE_ABOVE_MIN(en_min), .BULK_ABOVE_95(bulk_95), .BULK_BELOW_THRESH(bulk_thr),
        .SYNC_MODE(sync_mode), .SYNC_PULSE(sync_pulse), .INT_PERIOD(int_per),
        .SD_BIT(sd_bit), .RAMP_CROSS(ramp_cross), .GATE(gate), .RAMP_RELEASE(ramp_rel),
        .BULK_GOOD(bulk_good), .COMP_FORCE(comp_force), .LOOP_WORD(loop_word),
        .SS_ACTIVE(ss_active), .SYNC_LOCKED(sync_locked));

    pdcs_stage_model stage_u (
        .clock(clock), .ramp_release(ramp_rel), .sync_on(sync_on), .sync_per(sync_per),
        .cross_dly(cross_dly), .sd_fill(sd_fill), .ramp_cross(ramp_cross),
        .sync_pulse(sync_pulse), .sd_bit(sd_bit));

    always #2.5 clock = ~clock;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask : tick

    task automatic test_end(input string name);
        $display("test %s finished", name);
    endtask : test_end

    task automatic test_done;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : test_done

    function automatic logic [15:0] start_ok(input int i);
        return (i == 7) ? 16'h0001 : 16'h0000;
    endfunction : start_ok

    function automatic logic [8:0] ss_next(input logic [8:0] w);
        return (w >= 9'h100) ? 9'h100 : w + 9'h001;
    endfunction : ss_next

    // port monitor, sampled where outputs are settled
    always @(negedge clock) begin
        cyc++;
        if (syn_q === 1'b0 && sync_pulse === 1'b1) begin
            rises++;
            rise_cyc = cyc;
            // locked sync edge restarts the off interval even while it runs
            if (rises > 6 && sync_locked === 1'b1 && ramp_rel === 1'b0) low_cnt = 0;
        end
        if (rel_q === 1'b1 && ramp_rel === 1'b0) begin
            gap = cyc - fall_cyc;
            fall_cyc = cyc;
            low_cnt = 0;
            armed = mon_on;
            if (sync_locked === 1'b1 && mon_on)
                check(16'(cyc == rise_cyc), 16'h0001, "sync edge to gate off");
        end
        if (ramp_rel === 1'b0) low_cnt++;
        else if (rel_q === 1'b0 && armed)
            check(16'(low_cnt >= pdcs_pkg::TOFF_CYC && low_cnt <= pdcs_pkg::TOFF_CYC + 1),
                  16'h0001, "off interval");
        if (gate === 1'b1 && gate_q === 1'b0) begin
            gate_ups++;
            check(16'(ramp_cross && rel_q), 16'h0001, "gate turn-on cause");
        end
        if (mon_on) check(16'(loop_word <= 9'h100), 16'h0001, "loop word limit");
        rel_q = ramp_rel;
        syn_q = sync_pulse;
        gate_q = gate;
    end

    initial begin
        #(90000 * 5);
        failures++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        test_done;
    end

    initial begin
        seed = 9;
        {rst_b, sup_start, sup_stop, bulk_min, line_on, en_min, bulk_95, bulk_thr} = 8'h00;
        {sync_mode, sync_on, mon_on, armed, rel_q, syn_q, gate_q} = 7'h00;
        int_per = 16'(2000 + {$random(seed)} % 400);
        sync_per = 16'(150 + {$random(seed)} % 40);
        cross_dly = 8'(5 + {$random(seed)} % 20);
        sd_fill = 8'($random(seed));
        tick(8);
        rst_b = 1'b1;
        tick(1);
        check(16'({gate, bulk_good, comp_force, ss_active, sync_locked, loop_word}), 16'h0000, "reset values");
        test_end("reset");
        for (int i = 0; i < 8; i++) begin
            {sup_start, bulk_min, line_on} = 3'(i);
            en_min = 1'b1;
            tick(2);
            check(16'(ss_active), start_ok(i), "start condition");
            sup_stop = 1'b1;
            tick(2);
            check(16'({ss_active, gate}), 16'h0000, "supply stop");
            {sup_start, bulk_min, line_on, sup_stop} = 4'h0;
        end
        test_end("start table");
        {sup_start, bulk_min, line_on} = 3'h7;
        tick(3);
        mon_on = 1'b1;
        v = loop_word;
        for (int k = 0; k < 2 * WIN && loop_word === v; k++) tick(1);
        v = loop_word;
        tick(WIN);
        check(16'(loop_word), 16'(ss_next(v)), "soft-start step");
        tick(3 * int_per);
        check(16'(gap), int_per, "internal period");
        check(16'(gate_ups > 0), 16'h0001, "gate switching");
        check(16'(bulk_good), 16'h0000, "bulk good during soft-start");
        for (int k = 0; k < 300 * WIN && loop_word !== 9'h100; k++) tick(1);
        tick(4 * WIN);
        check(16'(loop_word), 16'h0100, "soft-start ceiling");
        test_end("soft-start");
        rises = 0;
        sync_mode = 1'b1;
        sync_on = 1'b1;
        for (int k = 0; k < 8 * TMO && rises < 5; k++) tick(1);
        tick(3);
        check(16'(sync_locked), 16'h0000, "locked too early");
        for (int k = 0; k < 2 * TMO && rises < 6; k++) tick(1);
        tick(4);
        check(16'(sync_locked), 16'h0001, "locked after six");
        tick(4 * sync_per);
        check(16'(gap), sync_per, "sync period");
        for (int k = 0; k < 2 * TMO && syn_q !== 1'b0; k++) tick(1);
        for (int k = 0; k < 2 * TMO && sync_pulse !== 1'b1; k++) tick(1);
        sync_on = 1'b0;
        tick(150);
        check(16'(sync_locked), 16'h0001, "lock held before timeout");
        tick(60);
        check(16'(sync_locked), 16'h0000, "sync timeout");
        test_end("sync");
        bulk_95 = 1'b1;
        tick(2);
        check(16'({ss_active, bulk_good}), 16'h0001, "normal entry");
        sd_fill = 8'hff;
        for (int k = 0; k < 400 * WIN && loop_word !== 9'h000; k++) tick(1);
        check(16'(loop_word), 16'h0000, "loop word falls");
        bulk_thr = 1'b1;
        tick(2);
        check(16'(bulk_good), 16'h0000, "bulk good drop");
        test_end("voltage loop");
        mon_on = 1'b0;
        armed = 1'b0;
        en_min = 1'b0;
        tick(2);
        check(16'({comp_force, gate, bulk_good, loop_word}), 16'h0800, "standby");
        en_min = 1'b1;
        tick(4);
        check(16'(comp_force), 16'h0000, "standby exit");
        bulk_min = 1'b0;
        tick(2);
        check(16'({comp_force, gate}), 16'h0002, "bulk low standby");
        sup_stop = 1'b1;
        tick(2);
        check(16'({comp_force, ss_active, gate}), 16'h0000, "lockout");
        test_end("standby");
        test_done;
    end
endmodule : testbench
